/* rtl/fsr_ctrl.sv */
// Self-programming control and fuse, lock and signature readback.
// Assumes CPU pulses, pointer and EEPROM busy come from logic on clk_i;
// fuse, lock, calibration and serial values are static nonvolatile levels.
`timescale 1ns/1ps
module fsr_ctrl #(
  parameter int unsigned PROG_CYCLES = fsr_pkg::PROG_CYCLES,
  // Arbitrary neutral signature values
  parameter logic [7:0] SIG_BYTE1 = 8'h11,
  parameter logic [7:0] SIG_BYTE2 = 8'h22,
  parameter logic [7:0] SIG_BYTE3 = 8'h33
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic por_resetn_i,
  // Control register access
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  output logic [7:0] ctrl_rdata_o,
  // Program-memory instructions
  input wire logic load_i,
  input wire logic store_i,
  input wire logic [15:0] z_ptr_i,
  input wire logic [15:0] store_data_i,
  input wire logic [7:0] pm_data_i,
  output logic [7:0] load_data_o,
  output logic load_valid_o,
  // EEPROM busy and nonvolatile values
  input wire logic eeprom_write_busy_i,
  input wire logic [7:0] fuse_low_byte_i,
  input wire logic [7:0] fuse_high_byte_i,
  input wire logic [7:0] extended_fuse_byte_i,
  input wire logic [7:0] lock_bits_i,
  input wire logic [7:0] osc_cal_i,
  input wire logic [79:0] serial_number_i,
  // Flash array commands
  output logic page_erase_cmd_o,
  output logic page_write_cmd_o,
  output logic buf_fill_o,
  output logic lock_write_o,
  output logic buf_clear_o,
  output logic [15:0] flash_addr_o,
  output logic [15:0] flash_wdata_o,
  output logic flash_busy_o,
  // Interrupt
  output logic spm_irq_o
);
  import fsr_pkg::*;

  localparam logic [15:0] PROG_LOAD = 16'(PROG_CYCLES - 1);

  fsr_ctl_t ctl_q, ctl_d;
  fsr_tmr_t tmr_q, tmr_d;

  // ****************************************
  // Readback decode
  // ****************************************
  function automatic logic [7:0] fuse_lock_byte(input logic [15:0] z, input logic [7:0] fuse_low_byte,
                                                input logic [7:0] fuse_high_byte, input logic [7:0] efb,
                                                input logic [7:0] lck);
    // Programmed bits are stored as zero, so values pass uninverted; the extended fuse keeps bits 2..0 only
    case (z)
      Z_FUSE_LOW: fuse_lock_byte = fuse_low_byte; // [RULE7] [RULE10]
      Z_LOCK: fuse_lock_byte = lck; // [RULE4] [RULE10]
      Z_FUSE_EXT: fuse_lock_byte = efb & EXT_FUSE_MASK; // [RULE9]
      Z_FUSE_HIGH: fuse_lock_byte = fuse_high_byte; // [RULE8]
      default: fuse_lock_byte = RESERVED_READ;
    endcase
  endfunction

  function automatic logic [7:0] sig_byte(input logic [15:0] z, input logic [7:0] cal,
                                          input logic [79:0] sn);
    logic [15:0] idx;
    idx = z - Z_SERIAL_FIRST;
    sig_byte = RESERVED_READ;
    case (z)
      Z_SIG1: sig_byte = SIG_BYTE1; // [RULE13]
      Z_SIG2: sig_byte = SIG_BYTE2; // [RULE13]
      Z_SIG3: sig_byte = SIG_BYTE3; // [RULE13]
      Z_CAL: sig_byte = cal; // [RULE14]
      default: begin
        // Ten serial bytes from the first serial address upward
        if (z >= Z_SERIAL_FIRST && idx < 16'(SERIAL_BYTES)) begin
          sig_byte = sn[idx[3:0]*8 +: 8]; // [RULE15]
        end
      end
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic start;
    logic in_rww;
    logic en_bit;
    start = 1'b0;
    en_bit = 1'b0;
    in_rww = (z_ptr_i < NO_READ_WHILE_WRITE_SECTION_BASE);
    ctl_d = ctl_q;
    tmr_d = tmr_q;
    ctl_d.erase = 1'b0;
    ctl_d.write = 1'b0;
    ctl_d.fill = 1'b0;
    ctl_d.lock_wr = 1'b0;
    ctl_d.buf_clear = 1'b0;
    ctl_d.load_valid = 1'b0;
    ctl_d.age = ctl_q.age + 3'h1;

    // Armed modes run out on their own
    case (ctl_q.mode)
      FSR_IDLE: ctl_d.age = 3'h0;
      FSR_CMD: begin
        if (store_i) begin
          ctl_d.mode = FSR_IDLE; // [RULE22]
          ctl_d.addr = z_ptr_i;
          ctl_d.wdata = store_data_i;
          if (ctl_q.cmd[BIT_ERASE]) begin
            ctl_d.erase = 1'b1;
            start = 1'b1;
            tmr_d.read_while_write_section = tmr_q.read_while_write_section | in_rww; // [RULE23]
          end else if (ctl_q.cmd[BIT_WRITE]) begin
            ctl_d.write = 1'b1;
            start = 1'b1;
            tmr_d.read_while_write_section = tmr_q.read_while_write_section | in_rww; // [RULE23]
          end else if (ctl_q.cmd[BIT_REEN]) begin
            ctl_d.buf_clear = 1'b1;
            if (!tmr_q.busy) begin
              tmr_d.read_while_write_section = 1'b0;
            end
          end else begin
            ctl_d.fill = 1'b1;
          end
        end else if (ctl_q.age == STORE_WIN - 3'h1) begin
          ctl_d.mode = FSR_IDLE; // [RULE22]
        end
      end
      FSR_LOCK: begin
        if (store_i) begin
          ctl_d.mode = FSR_IDLE; // [RULE5]
          ctl_d.lock_wr = 1'b1;
          ctl_d.wdata = store_data_i;
          ctl_d.addr = z_ptr_i;
          start = 1'b1;
        end else if (load_i && ctl_q.age < LOAD_WIN) begin
          ctl_d.mode = FSR_IDLE; // [RULE5]
        end else if (ctl_q.age == STORE_WIN - 3'h1) begin
          ctl_d.mode = FSR_IDLE; // [RULE5]
        end
      end
      FSR_SIG: begin
        if (load_i || ctl_q.age == LOAD_WIN - 3'h1) begin
          ctl_d.mode = FSR_IDLE; // [RULE12]
        end
      end
      default: ctl_d.mode = FSR_IDLE;
    endcase

    // Load readback; a late load in an armed mode sees plain memory
    if (load_i) begin
      ctl_d.load_valid = 1'b1;
      ctl_d.load_data = pm_data_i; // [RULE6]
      if (ctl_q.mode == FSR_LOCK && ctl_q.age < LOAD_WIN && !eeprom_write_busy_i) begin // [RULE2]
        ctl_d.load_data = fuse_lock_byte(z_ptr_i, fuse_low_byte_i, fuse_high_byte_i,
                                         extended_fuse_byte_i, lock_bits_i); // [RULE4]
      end else if (ctl_q.mode == FSR_SIG && ctl_q.age < LOAD_WIN) begin
        ctl_d.load_data = sig_byte(z_ptr_i, osc_cal_i, serial_number_i); // [RULE11]
      end
    end

    // Control writes; programming commands need an idle flash and EEPROM
    if (ctrl_wr_i) begin
      ctl_d.int_en = ctrl_wdata_i[BIT_INTEN];
      en_bit = ctrl_wdata_i[BIT_ENABLE];
      if (en_bit && !eeprom_write_busy_i && !tmr_q.busy) begin // [RULE1] [RULE25]
        ctl_d.cmd = ctrl_wdata_i;
        ctl_d.age = 3'h0;
        if (ctrl_wdata_i[BIT_SIG]) begin
          ctl_d.mode = FSR_SIG; // [RULE11]
        end else if (ctrl_wdata_i[BIT_LOCK]) begin
          ctl_d.mode = FSR_LOCK; // [RULE4]
        end else begin
          ctl_d.mode = FSR_CMD;
        end
      end
    end

    // Programming timer survives system reset
    if (start) begin
      tmr_d.busy = 1'b1; // [RULE18]
      tmr_d.cnt = PROG_LOAD;
    end else if (tmr_q.busy) begin
      if (tmr_q.cnt == 16'h0000) begin
        tmr_d.busy = 1'b0;
      end else begin
        tmr_d.cnt = tmr_q.cnt - 16'h0001;
      end
    end

    // Enable bit stays set until the timed operation is over
    ctl_d.rdata = 8'h00;
    ctl_d.rdata[BIT_ENABLE] = (ctl_d.mode != FSR_IDLE) || tmr_d.busy;
    ctl_d.rdata[BIT_ERASE] = (ctl_d.mode == FSR_CMD) && ctl_d.cmd[BIT_ERASE];
    ctl_d.rdata[BIT_WRITE] = (ctl_d.mode == FSR_CMD) && ctl_d.cmd[BIT_WRITE];
    ctl_d.rdata[BIT_LOCK] = (ctl_d.mode == FSR_LOCK);
    ctl_d.rdata[BIT_REEN] = (ctl_d.mode == FSR_CMD) && ctl_d.cmd[BIT_REEN];
    ctl_d.rdata[BIT_SIG] = (ctl_d.mode == FSR_SIG);
    ctl_d.rdata[BIT_RWWB] = tmr_d.read_while_write_section; // [RULE23]
    ctl_d.rdata[BIT_INTEN] = ctl_d.int_en;
    ctl_d.irq = ctl_d.int_en && !ctl_d.rdata[BIT_ENABLE]; // [RULE24]
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Only power-on clears the timer, so a reset cannot cut a write short
  always_ff @(posedge clk_i or negedge por_resetn_i) begin
    if (!por_resetn_i) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d; // [RULE17]
    end
  end

  assign ctrl_rdata_o = ctl_q.rdata;
  assign load_data_o = ctl_q.load_data;
  assign load_valid_o = ctl_q.load_valid;
  assign page_erase_cmd_o = ctl_q.erase;
  assign page_write_cmd_o = ctl_q.write;
  assign buf_fill_o = ctl_q.fill;
  assign lock_write_o = ctl_q.lock_wr;
  assign buf_clear_o = ctl_q.buf_clear;
  assign flash_addr_o = ctl_q.addr;
  assign flash_wdata_o = ctl_q.wdata;
  assign flash_busy_o = tmr_q.busy;
  assign spm_irq_o = ctl_q.irq;

  // ****************************************
  // Checks
  // ****************************************
  chk_ee_blocks_cmd: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE1]
    ctl_q.mode == FSR_IDLE && ctrl_wr_i && eeprom_write_busy_i |=> ctl_q.mode == FSR_IDLE)
    else $error("command accepted during EEPROM write");
  chk_ee_blocks_fuse: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE2]
    load_i && eeprom_write_busy_i && ctl_q.mode == FSR_LOCK |=> load_data_o == $past(pm_data_i))
    else $error("fuse read during EEPROM write");
  chk_lock_read: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE4]
    ctl_q.mode == FSR_LOCK && ctl_q.age < 3'h3 && load_i && !eeprom_write_busy_i && z_ptr_i == 16'h0001
    |=> load_valid_o && load_data_o == $past(lock_bits_i) && ctl_q.mode == FSR_IDLE)
    else $error("lock bits not returned");
  chk_lock_expiry: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE5]
    ctrl_wr_i && ctrl_wdata_i == 8'h09 && !eeprom_write_busy_i && !tmr_q.busy
    ##1 (!store_i && !load_i && !ctrl_wr_i) [*4] |=> ctl_q.mode == FSR_IDLE)
    else $error("lock access did not expire after four cycles");
  chk_plain_load: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE6]
    ctl_q.mode == FSR_IDLE && load_i |=> load_data_o == $past(pm_data_i))
    else $error("disarmed load not from program memory");
  chk_sig_expiry: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE12]
    ctl_q.mode == FSR_SIG && ctl_q.age == 3'h2 && !ctrl_wr_i |=> ctl_q.mode == FSR_IDLE)
    else $error("signature mode did not expire");
  chk_sig_calib: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE14]
    ctl_q.mode == FSR_SIG && ctl_q.age < 3'h3 && load_i && z_ptr_i == 16'h0001
    |=> load_data_o == $past(osc_cal_i))
    else $error("calibration byte not returned");
  chk_prog_time: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE18]
    $rose(tmr_q.busy) |-> tmr_q.cnt == PROG_LOAD && PROG_CYCLES >= 37000 && PROG_CYCLES <= 45000)
    else $error("programming time out of range");
  chk_rww_hold: assert property (@(posedge clk_i) disable iff (!por_resetn_i) // [RULE23]
    tmr_q.busy && tmr_q.read_while_write_section |=> tmr_q.read_while_write_section)
    else $error("read-while-write busy dropped during operation");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE24]
    ctl_q.int_en && ctl_q.mode == FSR_IDLE && !tmr_q.busy |-> spm_irq_o)
    else $error("interrupt not asserted while enable clear");
endmodule

/* shared/fsr_pkg.sv */
// Constants and types for the flash self-program and readback control block.
// Assumes a CPU core on the same clock that reports load and store
// program-memory instructions as one-cycle pulses.
//
// How it works
// [RULE1] Programming commands are refused while an EEPROM write is busy.
// [RULE2] Fuse and lock reads return plain program memory while EEPROM write is busy.
// [RULE3] Software polls EEPROM write-busy before writing the control register.
// [RULE4] Pointer 0x0001 with lock access armed: load within three cycles returns lock bits.
// [RULE5] Lock access disarms on read, or no load in three / store in four cycles.
// [RULE6] Disarmed, a load returns ordinary program memory.
// [RULE7] Lock access armed, pointer 0x0000 returns fuse low byte.
// [RULE8] Lock access armed, pointer 0x0003 returns fuse high byte.
// [RULE9] Pointer 0x0002 returns extended fuse byte; only bits 2..0 defined.
// [RULE10] Programmed bits read zero, unprogrammed read one.
// [RULE11] Signature armed: a load within three cycles returns the addressed signature byte.
// [RULE12] Signature mode disarms on read or after three cycles without load.
// [RULE13] Signature pointers 0x0000, 0x0002, 0x0004 give signature bytes one to three.
// [RULE14] Signature pointer 0x0001 gives the oscillator calibration byte.
// [RULE15] Ten-byte unique serial number readable in the signature row from 0x000E.
// [RULE16] Software ignores reserved signature-row addresses.
// [RULE17] A flash write in progress completes across a system reset.
// [RULE18] Erase, page write and lock write are timed between 3.7 ms and 4.5 ms.
// [RULE19] Software waits for enable bit clear before the next command.
// [RULE20] Software disables interrupts around control write plus store.
// [RULE21] Software re-enables the read-while-write section until busy reads clear.
// [RULE22] A command acts only if the store follows within four cycles.
// [RULE23] Read-while-write busy stays set while that section is erased or written.
// [RULE24] Interrupt stays asserted while enabled and enable bit is clear.
// [RULE25] A command written during an EEPROM write is ignored entirely; the code still takes the interrupt-enable bit from that write.
package fsr_pkg;
  // ****************************************
  // Control register fields
  // ****************************************
  localparam int BIT_ENABLE = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_LOCK = 3;
  localparam int BIT_REEN = 4;
  localparam int BIT_SIG = 5;
  localparam int BIT_RWWB = 6;
  localparam int BIT_INTEN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // Pointer addresses
  // ****************************************
  localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] Z_SIG1 = 16'h0000;
  localparam logic [15:0] Z_CAL = 16'h0001;
  localparam logic [15:0] Z_SIG2 = 16'h0002;
  localparam logic [15:0] Z_SIG3 = 16'h0004;
  localparam logic [15:0] Z_SERIAL_FIRST = 16'h000e;
  localparam logic [15:0] Z_SERIAL_LAST = 16'h0018;
  localparam int SERIAL_BYTES = 10;
  localparam logic [7:0] EXT_FUSE_MASK = 8'h07;
  localparam logic [7:0] RESERVED_READ = 8'hff;
  // First byte address of the no-read-while-write section
  localparam logic [15:0] NO_READ_WHILE_WRITE_SECTION_BASE = 16'h1000;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [2:0] LOAD_WIN = 3'h3;
  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_MIN_NS = 3700000;
  localparam int PROG_MAX_NS = 4500000;
  localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    FSR_IDLE = 2'h0,
    FSR_CMD = 2'h1,
    FSR_LOCK = 2'h3,
    FSR_SIG = 2'h2
  } fsr_mode_t;

  typedef struct packed {
    fsr_mode_t mode;
    logic [2:0] age;
    logic [7:0] cmd;
    logic int_en;
    logic [7:0] load_data;
    logic load_valid;
    logic [7:0] rdata;
    logic irq;
    logic erase;
    logic write;
    logic fill;
    logic lock_wr;
    logic buf_clear;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fsr_ctl_t;

  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
    logic read_while_write_section;
  } fsr_tmr_t;
endpackage

/* tb/flash_self_program_readback_control_tb_top.sv */
// Self-checking bench for the self-program and readback control block.
// Assumes fsr_cpu_model stands in for the CPU core; default timing is kept.
`timescale 1ns/1ps
module flash_self_program_readback_control_tb_top;
  import fsr_pkg::*;
  typedef struct packed {
    logic [7:0] wd;
    logic [15:0] z;
    logic [2:0] gap;
    logic ee;
    logic [7:0] exp;
  } fsr_row_t;
  logic clk_i, resetn_i, por_resetn_i, ctrl_wr_i, load_i, store_i, eeprom_write_busy_i;
  logic load_valid_o, page_erase_cmd_o, page_write_cmd_o, buf_fill_o, lock_write_o;
  logic buf_clear_o, flash_busy_o, spm_irq_o;
  logic [7:0] ctrl_wdata_i, ctrl_rdata_o, pm_data_i, load_data_o, lock_bits_i;
  logic [15:0] z_ptr_i, store_data_i, flash_addr_o, flash_wdata_o;
  fsr_row_t rows [14];
  int fails = 0;
  int check_count = 0;
  int erase_n = 0;
  int fill_n = 0;
  int clear_n = 0;
  int n;

  fsr_ctrl i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .por_resetn_i(por_resetn_i),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
    .load_i(load_i), .store_i(store_i), .z_ptr_i(z_ptr_i), .store_data_i(store_data_i),
    .pm_data_i(pm_data_i), .load_data_o(load_data_o), .load_valid_o(load_valid_o),
    .eeprom_write_busy_i(eeprom_write_busy_i), .fuse_low_byte_i(8'h5e), .fuse_high_byte_i(8'hd9),
    .extended_fuse_byte_i(8'hfa), .lock_bits_i(lock_bits_i), .osc_cal_i(8'h7b),
    .serial_number_i(80'ha998877665544332211_0), .page_erase_cmd_o(page_erase_cmd_o),
    .page_write_cmd_o(page_write_cmd_o), .buf_fill_o(buf_fill_o), .lock_write_o(lock_write_o),
    .buf_clear_o(buf_clear_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
    .flash_busy_o(flash_busy_o), .spm_irq_o(spm_irq_o));
  fsr_cpu_model i_cpu (.clk_i(clk_i), .eeprom_write_busy_i(eeprom_write_busy_i),
    .ctrl_rdata_i(ctrl_rdata_o), .ctrl_wr_o(ctrl_wr_i), .ctrl_wdata_o(ctrl_wdata_i),
    .load_o(load_i), .store_o(store_i), .z_o(z_ptr_i), .store_data_o(store_data_i),
    .pm_data_o(pm_data_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    erase_n += page_erase_cmd_o;
    fill_n += buf_fill_o;
    clear_n += buf_clear_o;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // *****
  // Main sequence
  // *****
  initial begin
    resetn_i = 1'b0;
    por_resetn_i = 1'b0;
    eeprom_write_busy_i = 1'b0;
    lock_bits_i = 8'hec;
    // Only listed signature-row addresses are read
    rows = '{'{8'h09, 16'h0001, 3'h0, 1'b0, 8'hec}, '{8'h09, 16'h0000, 3'h2, 1'b0, 8'h5e},
      '{8'h09, 16'h0003, 3'h1, 1'b0, 8'hd9}, '{8'h09, 16'h0002, 3'h0, 1'b0, 8'h02},
      '{8'h21, 16'h0000, 3'h0, 1'b0, 8'h11}, '{8'h21, 16'h0002, 3'h1, 1'b0, 8'h22},
      '{8'h21, 16'h0004, 3'h2, 1'b0, 8'h33}, '{8'h21, 16'h0001, 3'h0, 1'b0, 8'h7b},
      '{8'h21, 16'h000e, 3'h0, 1'b0, 8'h10}, '{8'h21, 16'h0017, 3'h0, 1'b0, 8'ha9},
      '{8'h00, 16'h0005, 3'h0, 1'b0, 8'h5f}, '{8'h09, 16'h0001, 3'h3, 1'b0, 8'h5b},
      '{8'h21, 16'h0000, 3'h3, 1'b0, 8'h5a}, '{8'h09, 16'h0001, 3'h0, 1'b1, 8'h5b}};
    repeat (20) @(negedge clk_i);
    check(ctrl_rdata_o, 16'h0000);
    check(load_valid_o, 16'h0000);
    resetn_i = 1'b1;
    por_resetn_i = 1'b1;
    foreach (rows[i]) begin
      eeprom_write_busy_i = rows[i].ee;
      i_cpu.run(rows[i].wd, rows[i].z, 16'h0000, 1, rows[i].gap, !rows[i].ee);
      check(load_valid_o, 16'h0001);
      check(load_data_o, rows[i].exp);
      check(ctrl_rdata_o[5:0], 16'h0000);
    end
    eeprom_write_busy_i = 1'b0;
    // *****
    // Awkward cases
    // *****
    // A second lock value shows the read is not a fixed pattern
    lock_bits_i = 8'hc3;
    i_cpu.run(8'h09, 16'h0001, 16'h0000, 1, 1, 1);
    check(load_data_o, 16'h00c3);
    // EEPROM write starts after arming: the load must see plain memory
    fork
      i_cpu.run(8'h09, 16'h0001, 16'h0000, 1, 1, 1);
      begin
        repeat (2) @(negedge clk_i);
        eeprom_write_busy_i = 1'b1;
      end
    join
    check(load_data_o, 16'h005b);
    check(ctrl_rdata_o[5:0], 16'h0000);
    eeprom_write_busy_i = 1'b0;
    i_cpu.run(8'h21, 16'h0000, 16'h0000, 0, 0, 1);
    check(ctrl_rdata_o, 16'h0021);
    repeat (3) @(negedge clk_i);
    check(ctrl_rdata_o[5:0], 16'h0000);
    i_cpu.run(8'h09, 16'h0001, 16'h0000, 0, 0, 1);
    repeat (2) @(negedge clk_i);
    check(ctrl_rdata_o, 16'h0009);
    repeat (2) @(negedge clk_i);
    check(ctrl_rdata_o[5:0], 16'h0000);
    // Command during an EEPROM write must leave no trace
    eeprom_write_busy_i = 1'b1;
    i_cpu.run(8'h03, 16'h0100, 16'h0000, 2, 0, 0);
    repeat (2) @(negedge clk_i);
    check(erase_n, 16'h0000);
    check({flash_busy_o, ctrl_rdata_o}, 16'h0000);
    eeprom_write_busy_i = 1'b0;
    i_cpu.run(8'h01, 16'h0002, 16'hbeef, 2, 4, 1);
    @(negedge clk_i);
    check(fill_n, 16'h0000);
    i_cpu.run(8'h01, 16'h0004, 16'hbeef, 2, 3, 1);
    @(negedge clk_i);
    check(fill_n, 16'h0001);
    check(flash_addr_o ^ flash_wdata_o, 16'hbeeb);
    i_cpu.run(8'h80, 16'h0000, 16'h0000, 0, 0, 1);
    @(negedge clk_i);
    check(spm_irq_o, 16'h0001);
    // Page write outside the read-while-write section, then a late lock write;
    // a power-on reset after each clears the timer to keep the run short
    i_cpu.run(8'h05, 16'h1000, 16'h0000, 2, 1, 1);
    check({page_write_cmd_o, flash_busy_o, ctrl_rdata_o}, 16'h0301);
    resetn_i = 1'b0;
    por_resetn_i = 1'b0;
    @(negedge clk_i);
    resetn_i = 1'b1;
    por_resetn_i = 1'b1;
    i_cpu.run(8'h09, 16'h0001, 16'hffc3, 2, 3, 1);
    check({lock_write_o, flash_busy_o, ctrl_rdata_o[6:0]}, 16'h0181);
    check(flash_wdata_o, 16'hffc3);
    resetn_i = 1'b0;
    por_resetn_i = 1'b0;
    @(negedge clk_i);
    resetn_i = 1'b1;
    por_resetn_i = 1'b1;
    // Erase in the read-while-write section, system reset in mid-run
    i_cpu.run(8'h83, 16'h0100, 16'h0000, 2, 0, 1);
    @(negedge clk_i);
    check(erase_n, 16'h0001);
    check({flash_busy_o, ctrl_rdata_o[6], spm_irq_o}, 16'h0006);
    resetn_i = 1'b0;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(flash_busy_o, 16'h0001);
    // Six falling edges have passed since busy was first seen high
    n = 6;
    while (flash_busy_o && n < 46000) begin
      @(negedge clk_i);
      n++;
    end
    check(n >= PROG_MIN_NS / CLK_PERIOD_NS && n <= PROG_MAX_NS / CLK_PERIOD_NS, 16'h0001);
    check(ctrl_rdata_o[6], 16'h0001);
    i_cpu.run(8'h11, 16'h0000, 16'h0000, 2, 0, 1);
    @(negedge clk_i);
    check({clear_n[7:0], ctrl_rdata_o[6]}, 16'h0002);
    report_and_stop();
  end

  // A hang costs one mismatch and ends the run the normal way
  initial begin
    #10_000_000;
    fails++;
    report_and_stop();
  end
endmodule

/* tb/fsr_cpu_model.sv */
// CPU core model: control writes and program-memory load/store pulses.
// Assumes the control block samples all requests on the rising edge.
`timescale 1ns/1ps
module fsr_cpu_model (
  // Clock and status
  input wire logic clk_i,
  input wire logic eeprom_write_busy_i,
  input wire logic [7:0] ctrl_rdata_i,
  // Requests
  output logic ctrl_wr_o,
  output logic [7:0] ctrl_wdata_o,
  output logic load_o,
  output logic store_o,
  output logic [15:0] z_o,
  output logic [15:0] store_data_o,
  output logic [7:0] pm_data_o
);
  initial begin
    ctrl_wr_o = 1'b0;
    ctrl_wdata_o = 8'h00;
    load_o = 1'b0;
    store_o = 1'b0;
    z_o = 16'h0000;
    store_data_o = 16'h0000;
  end
  // Plain program memory pattern, distinct from the readback value at each pointer the bench reads
  assign pm_data_o = z_o[7:0] ^ 8'h5a;
  // kind 1 is a load, 2 a store, 0 none; gap is idle cycles after the write.
  // The model never takes interrupts, so write and store are never split.
  task automatic run(input logic [7:0] wd, input logic [15:0] z, input logic [15:0] sd,
                     input int kind, input int gap, input bit polite);
    int n;
    n = 0;
    while (polite && (eeprom_write_busy_i || ctrl_rdata_i[0]) && n < 50000) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    z_o <= z;
    store_data_o <= sd;
    ctrl_wr_o <= 1'b1;
    ctrl_wdata_o <= wd;
    @(negedge clk_i);
    ctrl_wr_o <= 1'b0;
    repeat (gap) @(negedge clk_i);
    load_o <= (kind == 1);
    store_o <= (kind == 2);
    @(negedge clk_i);
    load_o <= 1'b0;
    store_o <= 1'b0;
  endtask
endmodule
